// file: logic/ssv_pkg.sv
// Package with constants and types of the safety supervisor.
package ssv_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   // Self-test cycle period in microseconds; value of our own choosing.
   localparam int unsigned SELFTEST_PERIOD_US = 1000;
   localparam int unsigned SELFTEST_PERIOD_CYC =
      (CLK_HZ / 1000000) * SELFTEST_PERIOD_US;
   localparam logic [11:0] FC_UNDER = 12'h001;
   localparam logic [11:0] FC_OVER = 12'hFF8;
   localparam logic [11:0] FC_UNKNOWN = 12'hFFA;
   localparam int unsigned WD_FRAMES = 4;
   localparam int unsigned LIM_HI_POS = 8;
   localparam int unsigned LIM_LO_POS = 0;
   // Write unlock key; value is arbitrary.
   localparam logic [31:0] UNLOCK_KEY = 32'hC0DE5AFE;
   // APB register offsets.
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_ERROR = 8'h04;
   localparam logic [7:0] OFS_TV_LIMIT = 8'h08;
   localparam logic [7:0] OFS_PV_LIMIT = 8'h0C;
   localparam logic [7:0] OFS_UNLOCK = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   // Enable register fields.
   localparam int unsigned EN_TV_POS = 0;
   localparam int unsigned EN_PV_POS = 1;
   localparam int unsigned EN_SAT_POS = 4;
   // Error register fields (sticky, write one to clear).
   localparam int unsigned ER_TV_POS = 0;
   localparam int unsigned ER_PV_POS = 1;
   localparam int unsigned ER_SAT_POS = 4;
   localparam int unsigned ER_WD_POS = 8;
   localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
   localparam logic [15:0] TV_LIMIT_RST = 16'h0000;
   localparam logic [15:0] PV_LIMIT_RST = 16'h0000;
   typedef enum {ST_RAMTEST, ST_RUN, ST_FAIL} ssv_state_t;
endpackage : ssv_pkg

// file: logic/ssv_top.sv
// Safety supervisor: memory checks, voters, saturation and frame watchdog.
// Contract
// - Run full RAM test once at start-up.
// - RAM parity always checked; failures reset chip.
// - Config memory CRC each period; mismatch resets.
// - Config writes refused unless unlocked by key.
// - Program memory CRC checked each test period.
// - Program words correct one, detect two errors.
// - Program CRC or double error resets chip.
// - Output register parity error resets chip.
// - Setting registers refreshed cyclically from storage.
// - Saturation sets bit, forces 1/4088/4090.
// - Saturation reported only when channel enabled; error register sat bits are set even when disabled.
// - Temperature vote after each new T1.
// - T2-T1 valid within twice min/max limits.
// - Temperature voter limits are signed eight-bit values.
// - Vote fail: flag, T1,P1,P2 become 4090.
// - Pressure vote: |P1-P2| within 16-bit limit.
// - Pressure vote fail: flag, P1,P2 become 4090.
// - Engine self-test each period; mismatch resets.
// - Illegal opcode resets immediately.
// - Stop transmitter after 4 stale frames.
`timescale 1ns/1ps
module ssv_top #(
   parameter int unsigned SELFTEST_CYC = ssv_pkg::SELFTEST_PERIOD_CYC,
   parameter int unsigned RAM_AW = 8
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RAM_PARITY_ERR,
   input wire logic CFG_CRC_DONE,
   input wire logic [2:0] CFG_CRC_MISMATCH,
   input wire logic PRG_CRC_DONE,
   input wire logic PRG_CRC_MISMATCH,
   input wire logic [21:0] PRG_CODEWORD,
   input wire logic PRG_READ,
   input wire logic OUT_REG_PARITY_ERR,
   input wire logic ENGINE_TEST_DONE,
   input wire logic ENGINE_TEST_FAIL,
   input wire logic BAD_OPCODE,
   input wire logic CFG_WRITE_REQ,
   input wire logic [3:0] SAT_EVENT,
   input wire logic [3:0] SAT_DIR_KNOWN,
   input wire logic [3:0] SAT_OVER,
   input wire logic RESULT_VALID,
   input wire logic T1_NEW,
   input wire logic [11:0] T1_IN,
   input wire logic [11:0] T2_IN,
   input wire logic [11:0] P1_IN,
   input wire logic [11:0] P2_IN,
   input wire logic FRAME_SENT,
   output logic [11:0] T1_OUT,
   output logic [11:0] T2_OUT,
   output logic [11:0] P1_OUT,
   output logic [11:0] P2_OUT,
   output logic [3:0] DIAG_SAT,
   output logic [15:0] PRG_DATA,
   output logic CFG_WRITE_GRANT,
   output logic SELFTEST_START,
   output logic SETTING_REFRESH,
   output logic TX_STOP,
   output logic CHIP_RESET_REQ
);
   if (RAM_AW < 2 || RAM_AW > 12 || SELFTEST_CYC < 2) begin : g_param_check
      $error("ssv_top: unsupported parameter values.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Register bus. Zero wait states; unmapped offsets read zero, PSLVERR.
   logic [31:0] enable_reg;
   logic [15:0] tv_limit_reg;
   logic [15:0] pv_limit_reg;
   logic [8:0] error_reg;
   logic unlock_reg;
   ssv_pkg::ssv_state_t state_reg;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && !PENABLE && !PWRITE;
   assign mapped = (PADDR == ssv_pkg::OFS_ENABLE) ||
      (PADDR == ssv_pkg::OFS_ERROR) || (PADDR == ssv_pkg::OFS_TV_LIMIT) ||
      (PADDR == ssv_pkg::OFS_PV_LIMIT) || (PADDR == ssv_pkg::OFS_UNLOCK) ||
      (PADDR == ssv_pkg::OFS_STATUS);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         enable_reg <= ssv_pkg::ENABLE_RST;
         tv_limit_reg <= ssv_pkg::TV_LIMIT_RST;
         pv_limit_reg <= ssv_pkg::PV_LIMIT_RST;
      end else if (wr_acc) begin
         case (PADDR)
            ssv_pkg::OFS_ENABLE: enable_reg <= PWDATA;
            ssv_pkg::OFS_TV_LIMIT: tv_limit_reg <= PWDATA[15:0];
            ssv_pkg::OFS_PV_LIMIT: pv_limit_reg <= PWDATA[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRDATA <= 32'h0000_0000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !mapped;
         if (rd_acc) begin
            case (PADDR)
               ssv_pkg::OFS_ENABLE: PRDATA <= enable_reg;
               ssv_pkg::OFS_ERROR: PRDATA <= {23'h0, error_reg};
               ssv_pkg::OFS_TV_LIMIT: PRDATA <= {16'h0, tv_limit_reg};
               ssv_pkg::OFS_PV_LIMIT: PRDATA <= {16'h0, pv_limit_reg};
               ssv_pkg::OFS_STATUS: PRDATA <= {29'h0, unlock_reg,
                  state_reg == ssv_pkg::ST_RUN, CHIP_RESET_REQ};
               default: PRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write unlock: a key write arms one grant; any other value relocks.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         unlock_reg <= 1'b0;
         CFG_WRITE_GRANT <= 1'b0;
      end else begin
         CFG_WRITE_GRANT <= CFG_WRITE_REQ && unlock_reg;
         if (wr_acc && PADDR == ssv_pkg::OFS_UNLOCK) begin
            unlock_reg <= (PWDATA == ssv_pkg::UNLOCK_KEY);
         end else if (CFG_WRITE_REQ) begin
            unlock_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start-up RAM test: march write address, then read back with parity.
   localparam int unsigned RAM_N = 1 << RAM_AW;
   logic [8:0] ram_mem [RAM_N];
   logic [RAM_AW:0] ram_ptr_reg;
   logic ram_fail_reg;
   logic [7:0] ram_pat;
   assign ram_pat = 8'(ram_ptr_reg[RAM_AW-1:0]) ^ 8'hA5;

   always_ff @(posedge CLK) begin
      if (state_reg == ssv_pkg::ST_RAMTEST && !ram_ptr_reg[RAM_AW]) begin
         ram_mem[ram_ptr_reg[RAM_AW-1:0]] <= {^ram_pat, ram_pat};
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ssv_pkg::ST_RAMTEST;
         ram_ptr_reg <= '0;
         ram_fail_reg <= 1'b0;
      end else begin
         case (state_reg)
            ssv_pkg::ST_RAMTEST: begin
               ram_ptr_reg <= ram_ptr_reg + 1'b1;
               if (ram_ptr_reg[RAM_AW]) begin
                  if (ram_mem[ram_ptr_reg[RAM_AW-1:0]] !=
                     {^ram_pat, ram_pat}) begin
                     ram_fail_reg <= 1'b1;
                  end
                  if (&ram_ptr_reg[RAM_AW-1:0]) begin
                     state_reg <= ssv_pkg::ST_RUN;
                  end
               end
            end
            ssv_pkg::ST_RUN: begin
               if (CHIP_RESET_REQ) begin
                  state_reg <= ssv_pkg::ST_FAIL;
               end
            end
            ssv_pkg::ST_FAIL: ;
            default: state_reg <= ssv_pkg::ST_FAIL;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Program memory: Hamming(21,16) plus overall parity, SEC-DED.
   logic [4:0] syn;
   logic ovp;
   logic [21:0] cw_fix;
   logic dbl_err;
   always_comb begin
      syn = '0;
      for (int i = 1; i <= 21; i++) begin
         if (PRG_CODEWORD[i]) begin
            syn = syn ^ 5'(i);
         end
      end
      ovp = ^PRG_CODEWORD;
      cw_fix = PRG_CODEWORD;
      if (ovp && syn != 5'h00 && syn <= 5'd21) begin
         cw_fix[syn] = ~PRG_CODEWORD[syn];
      end
      dbl_err = (!ovp && syn != 5'h00) || (ovp && syn > 5'd21);
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRG_DATA <= 16'h0000;
      end else if (PRG_READ) begin
         PRG_DATA <= {cw_fix[21:17], cw_fix[15:9], cw_fix[7:5],
            cw_fix[3]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Self-test period timer starts CRC, engine test and setting refresh.
   logic [31:0] per_cnt_reg;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         per_cnt_reg <= '0;
         SELFTEST_START <= 1'b0;
         SETTING_REFRESH <= 1'b0;
      end else begin
         SELFTEST_START <= 1'b0;
         SETTING_REFRESH <= 1'b0;
         if (state_reg == ssv_pkg::ST_RUN) begin
            if (per_cnt_reg == 32'(SELFTEST_CYC - 1)) begin
               per_cnt_reg <= '0;
               SELFTEST_START <= 1'b1;
               SETTING_REFRESH <= 1'b1;
            end else begin
               per_cnt_reg <= per_cnt_reg + 32'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset request collects every fatal check; held until chip reset.
   // Failures before the RAM test finishes are caught too.
   logic fatal;
   assign fatal = RAM_PARITY_ERR || ram_fail_reg ||
      (CFG_CRC_DONE && |CFG_CRC_MISMATCH) ||
      (PRG_CRC_DONE && PRG_CRC_MISMATCH) ||
      (PRG_READ && dbl_err) ||
      OUT_REG_PARITY_ERR ||
      (ENGINE_TEST_DONE && ENGINE_TEST_FAIL) ||
      BAD_OPCODE;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         CHIP_RESET_REQ <= 1'b0;
      end else if (fatal) begin
         CHIP_RESET_REQ <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Voters and saturation replacement on result path.
   logic signed [12:0] d_t;
   logic signed [9:0] lo2;
   logic signed [9:0] hi2;
   logic [11:0] d_p;
   logic tv_bad;
   logic pv_bad;
   logic [11:0] sat_val [4];
   logic [11:0] raw [4];
   assign d_t = $signed({1'b0, T2_IN}) - $signed({1'b0, T1_IN});
   // Limits are signed bytes scaled by two.
   assign lo2 = {{1{tv_limit_reg[ssv_pkg::LIM_LO_POS+7]}},
      tv_limit_reg[ssv_pkg::LIM_LO_POS +: 8], 1'b0};
   assign hi2 = {{1{tv_limit_reg[ssv_pkg::LIM_HI_POS+7]}},
      tv_limit_reg[ssv_pkg::LIM_HI_POS +: 8], 1'b0};
   assign tv_bad = enable_reg[ssv_pkg::EN_TV_POS] && T1_NEW &&
      (d_t < 13'(lo2) || d_t > 13'(hi2));
   assign d_p = (P1_IN >= P2_IN) ? P1_IN - P2_IN : P2_IN - P1_IN;
   assign pv_bad = enable_reg[ssv_pkg::EN_PV_POS] &&
      ({4'h0, d_p} > pv_limit_reg);
   assign raw[0] = T1_IN;
   assign raw[1] = T2_IN;
   assign raw[2] = P1_IN;
   assign raw[3] = P2_IN;
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         if (!SAT_EVENT[c]) begin
            sat_val[c] = raw[c];
         end else if (!SAT_DIR_KNOWN[c]) begin
            sat_val[c] = ssv_pkg::FC_UNKNOWN;
         end else if (SAT_OVER[c]) begin
            sat_val[c] = ssv_pkg::FC_OVER;
         end else begin
            sat_val[c] = ssv_pkg::FC_UNDER;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         T1_OUT <= 12'h000;
         T2_OUT <= 12'h000;
         P1_OUT <= 12'h000;
         P2_OUT <= 12'h000;
         DIAG_SAT <= 4'h0;
      end else if (RESULT_VALID) begin
         T1_OUT <= tv_bad ? ssv_pkg::FC_UNKNOWN : sat_val[0];
         T2_OUT <= sat_val[1];
         P1_OUT <= (tv_bad || pv_bad) ? ssv_pkg::FC_UNKNOWN :
            sat_val[2];
         P2_OUT <= (tv_bad || pv_bad) ? ssv_pkg::FC_UNKNOWN :
            sat_val[3];
         DIAG_SAT <= SAT_EVENT &
            enable_reg[ssv_pkg::EN_SAT_POS +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky error bits; a new event in the clearing cycle wins.
   logic [8:0] err_set;
   logic [8:0] err_clr;
   logic [2:0] stale_reg;
   assign err_set = {TX_STOP, RESULT_VALID ? SAT_EVENT : 4'h0, 2'h0,
      RESULT_VALID && pv_bad, RESULT_VALID && tv_bad};
   assign err_clr = (wr_acc && PADDR == ssv_pkg::OFS_ERROR) ?
      PWDATA[8:0] : 9'h000;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         error_reg <= 9'h000;
      end else begin
         error_reg <= (error_reg & ~err_clr) | err_set;
      end
   end

   // Frame watchdog: counts frames since last fresh result.
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         stale_reg <= 3'h0;
         TX_STOP <= 1'b0;
      end else begin
         if (RESULT_VALID) begin
            stale_reg <= 3'h0;
         end else if (FRAME_SENT && !TX_STOP) begin
            stale_reg <= stale_reg + 3'h1;
            if (stale_reg == 3'(ssv_pkg::WD_FRAMES - 1)) begin
               TX_STOP <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_reset_held: assert property (@(posedge CLK)
      disable iff (!RESETN) CHIP_RESET_REQ |=> CHIP_RESET_REQ)
      else $error("Reset request dropped.");
   a_opcode_reset: assert property (@(posedge CLK)
      disable iff (!RESETN) BAD_OPCODE |=> CHIP_RESET_REQ)
      else $error("Bad opcode did not request reset.");
   a_parity_reset: assert property (@(posedge CLK)
      disable iff (!RESETN) (RAM_PARITY_ERR || OUT_REG_PARITY_ERR)
      |=> CHIP_RESET_REQ)
      else $error("Parity error did not request reset.");
   a_crc_reset: assert property (@(posedge CLK)
      disable iff (!RESETN) (CFG_CRC_DONE && |CFG_CRC_MISMATCH)
      |=> CHIP_RESET_REQ)
      else $error("Config checksum failure ignored.");
   a_grant_locked: assert property (@(posedge CLK)
      disable iff (!RESETN) CFG_WRITE_GRANT |-> $past(unlock_reg))
      else $error("Write granted while locked.");
   a_tv_replace: assert property (@(posedge CLK)
      disable iff (!RESETN) (RESULT_VALID && tv_bad) |=> T1_OUT == 12'hFFA &&
      P1_OUT == 12'hFFA && P2_OUT == 12'hFFA && error_reg[0])
      else $error("Temperature vote failure not applied.");
   a_pv_replace: assert property (@(posedge CLK)
      disable iff (!RESETN) (RESULT_VALID && pv_bad) |=> P1_OUT == 12'hFFA &&
      P2_OUT == 12'hFFA && error_reg[1])
      else $error("Pressure vote failure not applied.");
   a_wd_stop: assert property (@(posedge CLK)
      disable iff (!RESETN) (FRAME_SENT && !RESULT_VALID &&
      stale_reg == 3'h3) |=> TX_STOP)
      else $error("Watchdog did not stop transmitter.");
   a_sat_unknown: assert property (@(posedge CLK)
      disable iff (!RESETN) (RESULT_VALID && SAT_EVENT[1] &&
      !SAT_DIR_KNOWN[1]) |=> T2_OUT == 12'hFFA)
      else $error("Unknown saturation not coded 4090.");
endmodule : ssv_top

// file: testbench/ssv_core_model.sv
// Model of the calculation core and frame transmitter feeding the supervisor.
`timescale 1ns/1ps
module ssv_core_model (
   input wire logic clk,
   output logic result_valid,
   output logic t1_new,
   output logic [11:0] t1,
   output logic [11:0] t2,
   output logic [11:0] p1,
   output logic [11:0] p2,
   output logic [3:0] sat_event,
   output logic [3:0] sat_dir_known,
   output logic [3:0] sat_over,
   output logic frame_sent
);
   initial begin
      result_valid = 1'b0;
      t1_new = 1'b0;
      {t1, t2, p1, p2} = '0;
      {sat_event, sat_dir_known, sat_over} = '0;
      frame_sent = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Data are inverted once the strobe drops, so a stale value is never seen.
   task automatic send(input logic [11:0] a, input logic [11:0] b,
                       input logic [11:0] c, input logic [11:0] d,
                       input logic nw, input logic [3:0] se,
                       input logic [3:0] dk, input logic [3:0] ov);
      @(posedge clk);
      result_valid <= 1'b1;
      t1_new <= nw;
      {t1, t2, p1, p2} <= {a, b, c, d};
      {sat_event, sat_dir_known, sat_over} <= {se, dk, ov};
      @(posedge clk);
      result_valid <= 1'b0;
      t1_new <= 1'b0;
      {t1, t2, p1, p2} <= ~{a, b, c, d};
      {sat_event, sat_dir_known, sat_over} <= ~{se, dk, ov};
   endtask : send
   ////////////////////////////////////////////////////////////////////////////
   task automatic frames(input int n);
      repeat (n) begin
         @(posedge clk);
         frame_sent <= 1'b1;
         @(posedge clk);
         frame_sent <= 1'b0;
      end
   endtask : frames
endmodule : ssv_core_model

// file: testbench/test_safety_supervisor.sv
// Self-checking bench of the safety supervisor.
`timescale 1ns/1ps
module test_safety_supervisor;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, rv, t1n, fs;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [9:0] flt;
   logic [2:0] cfg_mis;
   logic [21:0] cw;
   logic [3:0] sev, sdk, sov, diag;
   logic [11:0] t1i, t2i, p1i, p2i, t1o, t2o, p1o, p2o;
   logic [15:0] prg_data;
   logic grant, st_start, refresh, tx_stop, rst_req, e;
   int miscompares = 0;
   int check_count = 0;
   ////////////////////////////////////////////////////////////////////////////
   ssv_top #(.SELFTEST_CYC(50), .RAM_AW(3)) i_ssv_top (
      .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .RAM_PARITY_ERR(flt[0]),
      .OUT_REG_PARITY_ERR(flt[1]), .BAD_OPCODE(flt[2]),
      .CFG_CRC_DONE(flt[3]), .CFG_CRC_MISMATCH(cfg_mis),
      .PRG_CRC_DONE(flt[4]), .PRG_CRC_MISMATCH(flt[5]),
      .ENGINE_TEST_DONE(flt[6]), .ENGINE_TEST_FAIL(flt[7]),
      .CFG_WRITE_REQ(flt[8]), .PRG_READ(flt[9]), .PRG_CODEWORD(cw),
      .SAT_EVENT(sev), .SAT_DIR_KNOWN(sdk), .SAT_OVER(sov),
      .RESULT_VALID(rv), .T1_NEW(t1n), .T1_IN(t1i), .T2_IN(t2i),
      .P1_IN(p1i), .P2_IN(p2i), .FRAME_SENT(fs), .T1_OUT(t1o),
      .T2_OUT(t2o), .P1_OUT(p1o), .P2_OUT(p2o), .DIAG_SAT(diag),
      .PRG_DATA(prg_data), .CFG_WRITE_GRANT(grant),
      .SELFTEST_START(st_start), .SETTING_REFRESH(refresh),
      .TX_STOP(tx_stop), .CHIP_RESET_REQ(rst_req));
   ssv_core_model i_ssv_core_model (
      .clk(clk), .result_valid(rv), .t1_new(t1n), .t1(t1i), .t2(t2i),
      .p1(p1i), .p2(p2i), .sat_event(sev), .sat_dir_known(sdk),
      .sat_over(sov), .frame_sent(fs));
   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("wait states", 32'(n), 32'h1);
   endtask : apb
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, r, exp);
   endtask : rd
   task automatic do_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (20) @(posedge clk);
   endtask : do_reset
   task automatic pulse(input logic [9:0] p);
      @(posedge clk);
      flt <= p;
      @(posedge clk);
      flt <= '0;
      cfg_mis <= '0;
      @(negedge clk);
   endtask : pulse
   function automatic logic [21:0] enc(input logic [15:0] d);
      logic [21:0] c;
      int j;
      c = '0;
      j = 0;
      for (int p = 1; p < 22; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p] = d[j];
            j++;
         end
      end
      for (int k = 0; k < 5; k++) begin
         for (int p = 1; p < 22; p++) begin
            if (((p >> k) & 1) == 1 && p != (1 << k)) begin
               c[1 << k] = c[1 << k] ^ c[p];
            end
         end
      end
      c[0] = ^c[21:1];
      return c;
   endfunction : enc
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      do_reset();
      rd("enable", ssv_pkg::OFS_ENABLE, ssv_pkg::ENABLE_RST);
      rd("tvlim", ssv_pkg::OFS_TV_LIMIT, 32'(ssv_pkg::TV_LIMIT_RST));
      rd("pvlim", ssv_pkg::OFS_PV_LIMIT, 32'(ssv_pkg::PV_LIMIT_RST));
      rd("status", ssv_pkg::OFS_STATUS, 32'h2);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", {r[31:1], e}, 32'h1);
      apb(1'b1, ssv_pkg::OFS_ENABLE, 32'hF3);
      rd("enable", ssv_pkg::OFS_ENABLE, 32'hF3);
      $display("test regs done");
   endtask : t_regs
   task automatic t_unlock();
      do_reset();
      pulse(10'h100);
      chk("grant", 32'(grant), 32'h0);
      apb(1'b1, ssv_pkg::OFS_UNLOCK, ssv_pkg::UNLOCK_KEY ^ 32'h1);
      pulse(10'h100);
      chk("grant", 32'(grant), 32'h0);
      apb(1'b1, ssv_pkg::OFS_UNLOCK, ssv_pkg::UNLOCK_KEY);
      pulse(10'h100);
      chk("grant", 32'(grant), 32'h1);
      pulse(10'h100);
      chk("grant", 32'(grant), 32'h0);
      $display("test unlock done");
   endtask : t_unlock
   task automatic t_tvote();
      int t2v[5] = '{1048, 984, 1049, 983, 1049};
      logic f;
      do_reset();
      apb(1'b1, ssv_pkg::OFS_ENABLE, 32'h1);
      apb(1'b1, ssv_pkg::OFS_TV_LIMIT, 32'h18F8);
      for (int k = 0; k < 5; k++) begin
         f = (k == 2 || k == 3);
         i_ssv_core_model.send(12'd1000, 12'(t2v[k]), 12'd2000, 12'd2004,
                               k != 4, 4'h0, 4'h0, 4'h0);
         @(negedge clk);
         chk("t1", 32'(t1o), f ? 32'hFFA : 32'd1000);
         chk("t2", 32'(t2o), 32'(t2v[k]));
         chk("p1", 32'(p1o), f ? 32'hFFA : 32'd2000);
         chk("p2", 32'(p2o), f ? 32'hFFA : 32'd2004);
         rd("err", ssv_pkg::OFS_ERROR, 32'(f));
         apb(1'b1, ssv_pkg::OFS_ERROR, 32'hFFFF_FFFF);
      end
      $display("test tvote done");
   endtask : t_tvote
   task automatic t_pvote();
      int pa[4] = '{1000, 1000, 1205, 1204};
      int pb[4] = '{1204, 1205, 1000, 1000};
      logic f;
      do_reset();
      apb(1'b1, ssv_pkg::OFS_ENABLE, 32'h2);
      apb(1'b1, ssv_pkg::OFS_PV_LIMIT, 32'd204);
      for (int k = 0; k < 4; k++) begin
         f = (k == 1 || k == 2);
         i_ssv_core_model.send(12'd7, 12'd9, 12'(pa[k]), 12'(pb[k]),
                               1'b0, 4'h0, 4'h0, 4'h0);
         @(negedge clk);
         chk("p1", 32'(p1o), f ? 32'hFFA : 32'(pa[k]));
         chk("p2", 32'(p2o), f ? 32'hFFA : 32'(pb[k]));
         rd("err", ssv_pkg::OFS_ERROR, {30'h0, f, 1'b0});
         apb(1'b1, ssv_pkg::OFS_ERROR, 32'hFFFF_FFFF);
      end
      $display("test pvote done");
   endtask : t_pvote
   task automatic t_sat();
      do_reset();
      apb(1'b1, ssv_pkg::OFS_ENABLE, 32'h50);
      i_ssv_core_model.send(12'd100, 12'd200, 12'd300, 12'd400, 1'b1,
                            4'hF, 4'b0111, 4'b0101);
      @(negedge clk);
      chk("t1", 32'(t1o), 32'hFF8);
      chk("t2", 32'(t2o), 32'h001);
      chk("p1", 32'(p1o), 32'hFF8);
      chk("p2", 32'(p2o), 32'hFFA);
      chk("diag", 32'(diag), 32'h5);
      rd("err", ssv_pkg::OFS_ERROR, 32'hF0);
      $display("test sat done");
   endtask : t_sat
   task automatic t_ecc();
      logic [21:0] c;
      do_reset();
      c = enc(16'hA5C3);
      for (int b = 0; b < 22; b++) begin
         @(posedge clk);
         cw <= c ^ (22'h1 << b);
         pulse(10'h200);
         chk("data", 32'(prg_data), 32'hA5C3);
      end
      chk("rstreq", 32'(rst_req), 32'h0);
      @(posedge clk);
      cw <= c ^ 22'h001080;
      pulse(10'h200);
      repeat (2) @(negedge clk);
      chk("rstreq", 32'(rst_req), 32'h1);
      $display("test ecc done");
   endtask : t_ecc
   task automatic t_causes();
      logic [9:0] pat[7] = '{10'h001, 10'h002, 10'h004, 10'h008,
                             10'h030, 10'h0C0, 10'h058};
      for (int k = 0; k < 7; k++) begin
         do_reset();
         cfg_mis <= (k == 3) ? 3'b100 : 3'b000;
         pulse(pat[k]);
         repeat (3) @(negedge clk);
         chk("rstreq", 32'(rst_req), 32'(k != 6));
         @(negedge clk);
         chk("held", 32'(rst_req), 32'(k != 6));
      end
      $display("test causes done");
   endtask : t_causes
   task automatic t_period();
      int n;
      int rf;
      do_reset();
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (st_start !== 1'b1 && n < 500);
      chk("ramtest", 32'(n >= 16), 32'h1);
      n = 0;
      rf = 0;
      do begin
         rf += int'(refresh === 1'b1);
         @(negedge clk);
         n++;
      end while (st_start !== 1'b1 && n < 500);
      chk("period", 32'(n), 32'd50);
      chk("refresh", 32'(rf), 32'd1);
      $display("test period done");
   endtask : t_period
   task automatic t_wdog();
      do_reset();
      i_ssv_core_model.frames(3);
      i_ssv_core_model.send(12'd1, 12'd2, 12'd3, 12'd4, 1'b0, 4'h0, 4'h0,
                            4'h0);
      i_ssv_core_model.frames(3);
      @(negedge clk);
      chk("txstop", 32'(tx_stop), 32'h0);
      i_ssv_core_model.frames(1);
      @(negedge clk);
      chk("txstop", 32'(tx_stop), 32'h1);
      rd("err", ssv_pkg::OFS_ERROR, 32'h100);
      $display("test wdog done");
   endtask : t_wdog
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      clk = 1'b0;
      {resetn, psel, penable, pwrite} = '0;
      {paddr, pwdata, flt, cfg_mis, cw} = '0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_unlock();
      t_tvote();
      t_pvote();
      t_sat();
      t_ecc();
      t_causes();
      t_period();
      t_wdog();
      tally_and_finish();
   end
   // The whole run needs under 3000 cycles; this allows several times that.
   initial begin
      #1000000;
      miscompares++;
      tally_and_finish();
   end
endmodule : test_safety_supervisor
